//--- core/qdp_map.svh
// Register offsets, field positions and reset values of the queue data port
`ifndef QDP_MAP_SVH
`define QDP_MAP_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define QDP_ADDR_W 10
`define QDP_OFS_PACKET_SIZE 10'h004
`define QDP_OFS_TRANSMIT_SETUP 10'h008
`define QDP_OFS_TRANSMIT_DATA 10'h00c
`define QDP_OFS_RECEIVE_DATA 10'h010
`define QDP_OFS_CHAIN_POINTERS 10'h018

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define QDP_SETUP_ENDIAN_BIT 24
`define QDP_SETUP_START_HI 19
`define QDP_SETUP_START_LO 18
`define QDP_SETUP_END_HI 17
`define QDP_SETUP_END_LO 16
`define QDP_SETUP_COUNT_HI 13
`define QDP_SETUP_COUNT_LO 0
`define QDP_PTR_LAST_HI 22
`define QDP_PTR_LAST_LO 16
`define QDP_PTR_FIRST_HI 6
`define QDP_PTR_FIRST_LO 0
`define QDP_SIZE_HI 15
`define QDP_SIZE_LO 0

// ----------------------------------------------------------------
// Reset values and widths
// ----------------------------------------------------------------
`define QDP_COUNT_W 14
`define QDP_PTR_W 7
`define QDP_SIZE_W 16
`define QDP_RST_COUNT 14'h0000
`define QDP_RST_OFFSET 2'h0
`define QDP_RST_PTR 7'h00
`define QDP_RST_SIZE 16'h0000
`define QDP_RST_WORD 32'h0000_0000
`define QDP_WORD_BYTES 3'h4

`endif

//--- core/qdp_pkg.sv
// Types shared by the queue data port modules
`default_nettype none

package qdp_pkg;

    // Transmit byte order of a data word
    typedef enum logic {
        QDP_LSB_FIRST,
        QDP_MSB_FIRST
    } qdp_order_t;

    // Byte offset inside one 32-bit word
    typedef logic [1:0] qdp_ofs_t;

    // Number of valid bytes in one word, 0 to 4
    typedef logic [2:0] qdp_nbytes_t;

endpackage : qdp_pkg

`default_nettype wire

//--- core/qdp_pack_if.sv
// Interface between the port controller and the byte masking unit
`default_nettype none

interface qdp_pack_if;
    import qdp_pkg::*;

    logic [31:0] word;
    qdp_order_t order;
    qdp_nbytes_t lead;
    qdp_nbytes_t trail;
    logic [31:0] out_word;
    logic [3:0] out_mask;
    qdp_nbytes_t out_count;

    // Controller side
    modport ctrl (
        output word,
        output order,
        output lead,
        output trail,
        input out_word,
        input out_mask,
        input out_count
    );

    // Masking unit side
    modport mask (
        input word,
        input order,
        input lead,
        input trail,
        output out_word,
        output out_mask,
        output out_count
    );
endinterface : qdp_pack_if

`default_nettype wire

//--- core/qdp_byte_mask.sv
// Byte reordering and lead/trail masking of one transmit word
`default_nettype none

module qdp_byte_mask
    import qdp_pkg::*;
(
    // Packing link
    qdp_pack_if.mask pk
);

    // ----------------------------------------------------------------
    // Reorder so that lane 0 is always the first byte on the wire
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1)
        begin : g_lane
            // Lane gi keeps its byte when it sits between the lead and trail cuts
            assign pk.out_word[gi*8 +: 8] = (pk.order == QDP_MSB_FIRST) ?
                pk.word[(3-gi)*8 +: 8] : pk.word[gi*8 +: 8]; // R01
            assign pk.out_mask[gi] = (3'(gi) >= pk.lead) &&
                (3'(gi) < (3'h4 - pk.trail)); // R02 R04
        end
    endgenerate

    // Count of kept bytes, used to walk down the packet size
    always_comb
    begin
        pk.out_count = '0;
        for (int i = 0; i < 4; i++)
        begin
            pk.out_count = pk.out_count + qdp_nbytes_t'(pk.out_mask[i]);
        end
    end

endmodule : qdp_byte_mask

`default_nettype wire

//--- core/qdp_top.sv
// Host data port of one buffer chain: setup, transmit push, receive pop, pointers
//
// Summary of operation
// R01 - Byte-order bit picks first transmitted byte
// R02 - Drop start-offset leading bytes from first word
// R03 - Start offset used while count nonzero, self-clears
// R04 - Drop end-offset trailing bytes when count zero
// R05 - End offset persists until host clears it
// R06 - Packet size remainder below four overrides end
// R07 - Countdown decrements per write, holds at zero
// R08 - Host loads countdown with writes minus one
// R09 - Host sets control and size before setup
// R10 - Transmit data write appends word to chain
// R11 - Receive data read pops next chain word
// R12 - Readable writable seven-bit first, last pointers
// R13 - Host writes packet size before adding packet
// R14 - Setup write loads all fields at once
`default_nettype none
`include "qdp_map.svh"

module qdp_top
    import qdp_pkg::*;
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,

    // Host register port
    input wire logic [`QDP_ADDR_W-1:0] host_addr_i,
    input wire logic host_wr_i,
    input wire logic host_rd_i,
    input wire logic [31:0] host_wdata_i,
    output logic [31:0] host_rdata_o,

    // Transmit words into the buffer chain
    output logic tx_push_o,
    output logic [31:0] tx_word_o,
    output logic [3:0] tx_byte_en_o,

    // Receive words out of the buffer chain
    input wire logic [31:0] rx_word_i,
    output logic rx_pop_o,

    // Chain pointers as seen by the block allocator
    output logic [`QDP_PTR_W-1:0] chain_first_o,
    output logic [`QDP_PTR_W-1:0] chain_last_o
);

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic [`QDP_COUNT_W-1:0] count_ff;
    qdp_ofs_t start_ofs_ff;
    qdp_ofs_t end_ofs_ff;
    qdp_order_t order_ff;
    logic [`QDP_SIZE_W-1:0] size_ff;
    logic [`QDP_PTR_W-1:0] first_ff;
    logic [`QDP_PTR_W-1:0] last_ff;
    logic [31:0] rdata_ff;
    logic push_ff;
    logic [31:0] tx_word_ff;
    logic [3:0] tx_be_ff;

    // ----------------------------------------------------------------
    // Access decode
    // ----------------------------------------------------------------
    logic wr_size;
    logic wr_setup;
    logic wr_data;
    logic wr_ptr;
    logic rd_rx;

    assign wr_size = host_wr_i && (host_addr_i == `QDP_OFS_PACKET_SIZE);
    assign wr_setup = host_wr_i && (host_addr_i == `QDP_OFS_TRANSMIT_SETUP);
    assign wr_data = host_wr_i && (host_addr_i == `QDP_OFS_TRANSMIT_DATA);
    assign wr_ptr = host_wr_i && (host_addr_i == `QDP_OFS_CHAIN_POINTERS);
    assign rd_rx = host_rd_i && (host_addr_i == `QDP_OFS_RECEIVE_DATA);

    // ----------------------------------------------------------------
    // Byte masking of the word being written
    // ----------------------------------------------------------------
    qdp_pack_if pk ();

    logic count_zero;
    logic size_short;
    logic [`QDP_SIZE_W-1:0] nxt_size;

    assign count_zero = (count_ff == `QDP_RST_COUNT);
    // Fewer than a word of packet left: the remainder decides the cut
    assign size_short = (size_ff < `QDP_SIZE_W'(`QDP_WORD_BYTES));

    always_comb
    begin
        pk.word = host_wdata_i;
        pk.order = order_ff; // R01
        // Leading cut only while more writes are still expected
        pk.lead = count_zero ? 3'h0 : {1'b0, start_ofs_ff}; // R03
        if (size_short)
        begin
            // Keep exactly the bytes the packet still owes
            pk.trail = `QDP_WORD_BYTES - 3'(size_ff) - pk.lead; // R06
        end
        else if (count_zero)
        begin
            pk.trail = {1'b0, end_ofs_ff}; // R04 R05
        end
        else
        begin
            pk.trail = 3'h0;
        end
    end

    qdp_byte_mask u_mask (
        .pk(pk.mask)
    );

    // Remaining packet size walks down by kept bytes, never below zero
    always_comb
    begin
        if (size_ff > `QDP_SIZE_W'(pk.out_count))
        begin
            nxt_size = size_ff - `QDP_SIZE_W'(pk.out_count);
        end
        else
        begin
            nxt_size = `QDP_RST_SIZE;
        end
    end

    // ----------------------------------------------------------------
    // Packet size register
    // ----------------------------------------------------------------
    // Host loads the byte length ahead of the setup write
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            size_ff <= `QDP_RST_SIZE;
        end
        else if (wr_size)
        begin
            size_ff <= host_wdata_i[`QDP_SIZE_HI:`QDP_SIZE_LO]; // R13
        end
        else if (wr_data)
        begin
            size_ff <= nxt_size;
        end
    end

    // ----------------------------------------------------------------
    // Transmit setup: countdown and offsets
    // ----------------------------------------------------------------
    // Countdown: a setup write wins, else one step per data write
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            count_ff <= `QDP_RST_COUNT;
        end
        else if (wr_setup)
        begin
            count_ff <= host_wdata_i[`QDP_SETUP_COUNT_HI:`QDP_SETUP_COUNT_LO]; // R14 R08
        end
        else if (wr_data && !count_zero)
        begin
            count_ff <= count_ff - `QDP_COUNT_W'(1); // R07
        end
    end

    // Start offset is spent by the first write that uses it
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            start_ofs_ff <= `QDP_RST_OFFSET;
        end
        else if (wr_setup)
        begin
            start_ofs_ff <= host_wdata_i[`QDP_SETUP_START_HI:`QDP_SETUP_START_LO]; // R14
        end
        else if (wr_data && !count_zero)
        begin
            start_ofs_ff <= `QDP_RST_OFFSET; // R03
        end
    end

    // End offset and byte order change only by a setup write
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            end_ofs_ff <= `QDP_RST_OFFSET;
            order_ff <= QDP_LSB_FIRST;
        end
        else if (wr_setup)
        begin
            end_ofs_ff <= host_wdata_i[`QDP_SETUP_END_HI:`QDP_SETUP_END_LO]; // R05 R14
            order_ff <= qdp_order_t'(host_wdata_i[`QDP_SETUP_ENDIAN_BIT]); // R14
        end
    end

    // ----------------------------------------------------------------
    // Transmit push toward the chain
    // ----------------------------------------------------------------
    // Registered so the chain sees word and lanes in one clean cycle
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            push_ff <= 1'b0;
            tx_word_ff <= `QDP_RST_WORD;
            tx_be_ff <= 4'h0;
        end
        else
        begin
            push_ff <= wr_data; // R10
            if (wr_data)
            begin
                tx_word_ff <= pk.out_word; // R01
                tx_be_ff <= pk.out_mask; // R02 R04
            end
        end
    end

    // ----------------------------------------------------------------
    // Chain pointers
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            first_ff <= `QDP_RST_PTR;
            last_ff <= `QDP_RST_PTR;
        end
        else if (wr_ptr)
        begin
            first_ff <= host_wdata_i[`QDP_PTR_FIRST_HI:`QDP_PTR_FIRST_LO]; // R12
            last_ff <= host_wdata_i[`QDP_PTR_LAST_HI:`QDP_PTR_LAST_LO]; // R12
        end
    end

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    // Read data lands one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            rdata_ff <= `QDP_RST_WORD;
        end
        else if (host_rd_i)
        begin
            rdata_ff <= `QDP_RST_WORD;
            unique case (host_addr_i)
                `QDP_OFS_PACKET_SIZE:
                begin
                    rdata_ff[`QDP_SIZE_HI:`QDP_SIZE_LO] <= size_ff;
                end
                `QDP_OFS_TRANSMIT_SETUP:
                begin
                    rdata_ff[`QDP_SETUP_ENDIAN_BIT] <= order_ff;
                    rdata_ff[`QDP_SETUP_START_HI:`QDP_SETUP_START_LO] <= start_ofs_ff;
                    rdata_ff[`QDP_SETUP_END_HI:`QDP_SETUP_END_LO] <= end_ofs_ff;
                    rdata_ff[`QDP_SETUP_COUNT_HI:`QDP_SETUP_COUNT_LO] <= count_ff;
                end
                `QDP_OFS_RECEIVE_DATA:
                begin
                    rdata_ff <= rx_word_i; // R11
                end
                `QDP_OFS_CHAIN_POINTERS:
                begin
                    rdata_ff[`QDP_PTR_FIRST_HI:`QDP_PTR_FIRST_LO] <= first_ff; // R12
                    rdata_ff[`QDP_PTR_LAST_HI:`QDP_PTR_LAST_LO] <= last_ff; // R12
                end
                default:
                begin
                    rdata_ff <= `QDP_RST_WORD;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Pop is combinational so the chain advances in the read cycle itself
    assign rx_pop_o = rd_rx; // R11
    assign host_rdata_o = rdata_ff;
    assign tx_push_o = push_ff;
    assign tx_word_o = tx_word_ff;
    assign tx_byte_en_o = tx_be_ff;
    assign chain_first_o = first_ff;
    assign chain_last_o = last_ff;

endmodule : qdp_top

`default_nettype wire

//--- verification/qdp_top_properties.sv
// Concurrent checks on the queue data port pins
`default_nettype none
`include "qdp_map.svh"

module qdp_top_properties (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // Host port
    input wire logic [`QDP_ADDR_W-1:0] host_addr_i,
    input wire logic host_wr_i,
    input wire logic host_rd_i,
    input wire logic [31:0] host_wdata_i,
    input wire logic [31:0] host_rdata_o,
    // Chain side
    input wire logic tx_push_o,
    input wire logic [31:0] tx_word_o,
    input wire logic [3:0] tx_byte_en_o,
    input wire logic [31:0] rx_word_i,
    input wire logic rx_pop_o,
    input wire logic [`QDP_PTR_W-1:0] chain_first_o,
    input wire logic [`QDP_PTR_W-1:0] chain_last_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);

    // Decoded accesses and last write data, so pointer checks need no slice of $past
    wire tx_wr = host_wr_i && host_addr_i == `QDP_OFS_TRANSMIT_DATA;
    wire rx_rd = host_rd_i && host_addr_i == `QDP_OFS_RECEIVE_DATA;
    wire ptr_wr = host_wr_i && host_addr_i == `QDP_OFS_CHAIN_POINTERS;
    logic [31:0] wd_ff;
    always_ff @(posedge mclk_i)
    begin
        wd_ff <= host_wdata_i;
    end

    property p_push;
        tx_wr |=> tx_push_o;
    endproperty
    a_push: assert property (p_push) else $error("no push after data write");
    property p_push_cause;
        tx_push_o |-> $past(tx_wr);
    endproperty
    a_push_cause: assert property (p_push_cause) else $error("push without data write");
    property p_pop;
        rx_pop_o == rx_rd;
    endproperty
    a_pop: assert property (p_pop) else $error("pop not tied to receive read");
    property p_rx_data;
        rx_rd |=> host_rdata_o == $past(rx_word_i);
    endproperty
    a_rx_data: assert property (p_rx_data) else $error("receive word not returned");
    property p_rd_hold;
        !host_rd_i |=> $stable(host_rdata_o);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved without read");
    property p_ptr_wr;
        ptr_wr |=> chain_first_o == wd_ff[6:0] && chain_last_o == wd_ff[22:16];
    endproperty
    a_ptr_wr: assert property (p_ptr_wr) else $error("pointer write not taken");
    property p_ptr_hold;
        !ptr_wr |=> $stable({chain_first_o, chain_last_o});
    endproperty
    a_ptr_hold: assert property (p_ptr_hold) else $error("pointers moved without write");
    property p_word_hold;
        !tx_push_o |-> $stable(tx_word_o) && $stable(tx_byte_en_o);
    endproperty
    a_word_hold: assert property (p_word_hold) else $error("transmit word moved without push");

    // Main scenarios reached
    c_burst: cover property (tx_wr ##1 tx_wr ##1 tx_wr);
    c_rx_pair: cover property (rx_rd ##1 rx_rd);
    c_ptr: cover property (ptr_wr);
endmodule : qdp_top_properties

bind qdp_top qdp_top_properties qdp_top_properties_inst (.mclk_i, .rst_i, .host_addr_i, .host_wr_i, .host_rd_i,
    .host_wdata_i, .host_rdata_o, .tx_push_o, .tx_word_o, .tx_byte_en_o, .rx_word_i, .rx_pop_o,
    .chain_first_o, .chain_last_o);

`default_nettype wire

//--- verification/qdp_chain_model.sv
// Behavioural buffer chain behind the receive register
`default_nettype none

module qdp_chain_model (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // Head word and pop
    input wire logic rx_pop_i,
    output logic [31:0] rx_word_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] head_ff;

    // Words are numbered so a skipped or repeated pop shows in the data
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            head_ff <= 8'h00;
        else if (rx_pop_i)
            head_ff <= head_ff + 8'h01;
    end
    assign rx_word_o = {24'h5a_0000, head_ff};
endmodule : qdp_chain_model

`default_nettype wire

//--- verification/qdp_top_tb.sv
// Self-checking bench of the queue data port
`default_nettype none
`include "qdp_map.svh"

module qdp_top_tb;
    import qdp_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {logic [31:0] setup; logic [15:0] size; logic [31:0] word; logic [3:0] en; logic [31:0] back;} qdp_row_t;

    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic host_wr_i = 1'b0;
    logic host_rd_i = 1'b0;
    logic [`QDP_ADDR_W-1:0] host_addr_i = 10'h000;
    logic [31:0] host_wdata_i = 32'h0000_0000;
    logic [31:0] host_rdata_o;
    logic [31:0] tx_word_o;
    logic [31:0] rx_word_i;
    logic [3:0] tx_byte_en_o;
    logic tx_push_o;
    logic rx_pop_o;
    logic [`QDP_PTR_W-1:0] chain_first_o;
    logic [`QDP_PTR_W-1:0] chain_last_o;
    int bad_count = 0;
    int n_checks = 0;
    // Single writes: count zero unless a start offset is tested; data is 32'h4433_2211
    qdp_row_t rows [5] = '{
        '{32'h0000_0000, 16'h0064, 32'h4433_2211, 4'hf, 32'h0000_0000},
        '{32'h0101_0000, 16'h0064, 32'h1122_3344, 4'h7, 32'h0101_0000},
        '{32'h000b_0005, 16'h0064, 32'h4433_2211, 4'hc, 32'h0003_0004},
        '{32'h0000_0000, 16'h0002, 32'h4433_2211, 4'h3, 32'h0000_0000},
        '{32'h0104_0003, 16'h0002, 32'h1122_3344, 4'h6, 32'h0100_0002}};

    qdp_top qdp_top_inst (.mclk_i, .rst_i, .host_addr_i, .host_wr_i, .host_rd_i, .host_wdata_i, .host_rdata_o,
        .tx_push_o, .tx_word_o, .tx_byte_en_o, .rx_word_i, .rx_pop_o, .chain_first_o, .chain_last_o);
    qdp_chain_model qdp_chain_model_inst (.mclk_i, .rst_i, .rx_pop_i(rx_pop_o), .rx_word_o(rx_word_i));

    initial
    begin
        forever #50 mclk_i = ~mclk_i;
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // Called at a falling edge; strobes stay up until the next call so none is set twice per step
    task automatic acc(input logic wr, input logic rd, input logic [9:0] addr, input logic [31:0] data);
        host_wr_i = wr;
        host_rd_i = rd;
        host_addr_i = addr;
        host_wdata_i = data;
        @(negedge mclk_i);
    endtask : acc

    task automatic rd(input logic [9:0] addr, input logic [31:0] exp, input string name);
        acc(1'b0, 1'b1, addr, 32'h0000_0000);
        chk(name, host_rdata_o, exp);
    endtask : rd

    // Disabled lanes carry no promise, so only enabled lanes of the word are compared
    task automatic tx(input logic [31:0] data, input logic [3:0] en, input logic [31:0] word);
        logic [31:0] m;
        m = {{8{en[3]}}, {8{en[2]}}, {8{en[1]}}, {8{en[0]}}};
        acc(1'b1, 1'b0, `QDP_OFS_TRANSMIT_DATA, data);
        chk("push", {31'h0, tx_push_o}, 32'h1);
        chk("byte_en", {28'h0, tx_byte_en_o}, {28'h0, en});
        chk("word", tx_word_o & m, word & m);
    endtask : tx

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : print_verdict

    // Cuts a hang short
    initial
    begin
        #100000;
        bad_count++;
        print_verdict();
    end

    initial
    begin
        repeat (16) @(negedge mclk_i);
        rst_i = 1'b0;
        chk("tx_out", {tx_word_o[27:0], tx_byte_en_o}, 32'h0);
        rd(`QDP_OFS_TRANSMIT_SETUP, 32'h0, "setup_rst");
        rd(`QDP_OFS_CHAIN_POINTERS, 32'h0, "ptr_rst");
        rd(`QDP_OFS_PACKET_SIZE, 32'h0, "size_rst");
        foreach (rows[i])
        begin
            acc(1'b1, 1'b0, `QDP_OFS_PACKET_SIZE, {16'h0000, rows[i].size});
            acc(1'b1, 1'b0, `QDP_OFS_TRANSMIT_SETUP, rows[i].setup);
            tx(32'h4433_2211, rows[i].en, rows[i].word);
            rd(`QDP_OFS_TRANSMIT_SETUP, rows[i].back, "setup");
        end
        // Back-to-back packet of three words, then a late word after the count has run out
        acc(1'b1, 1'b0, `QDP_OFS_PACKET_SIZE, 32'h0000_000a);
        acc(1'b1, 1'b0, `QDP_OFS_TRANSMIT_SETUP, 32'h0105_0002);
        tx(32'ha1a2_a3a4, 4'he, 32'ha4a3_a2a1);
        tx(32'hb1b2_b3b4, 4'hf, 32'hb4b3_b2b1);
        tx(32'hc1c2_c3c4, 4'h7, 32'hc4c3_c2c1);
        rd(`QDP_OFS_TRANSMIT_SETUP, 32'h0101_0000, "setup_end");
        chk("push_idle", {31'h0, tx_push_o}, 32'h0);
        acc(1'b1, 1'b0, `QDP_OFS_PACKET_SIZE, 32'h0000_000a);
        tx(32'hd1d2_d3d4, 4'h7, 32'hd4d3_d2d1);
        rd(`QDP_OFS_TRANSMIT_SETUP, 32'h0101_0000, "setup_hold");
        // Pointers, reserved bits and refused places
        acc(1'b1, 1'b0, `QDP_OFS_CHAIN_POINTERS, 32'hffff_ff2a);
        acc(1'b1, 1'b0, 10'h3fc, 32'h0000_0000);
        rd(`QDP_OFS_CHAIN_POINTERS, 32'h007f_002a, "ptr");
        chk("ptr_pins", {18'h0, chain_last_o, chain_first_o}, 32'h3faa);
        acc(1'b1, 1'b0, `QDP_OFS_RECEIVE_DATA, 32'h1234_5678);
        chk("pop_on_write", {31'h0, rx_pop_o}, 32'h0);
        rd(`QDP_OFS_RECEIVE_DATA, 32'h5a00_0000, "rx0");
        rd(`QDP_OFS_RECEIVE_DATA, 32'h5a00_0001, "rx1");
        chk("pop_on_read", {31'h0, rx_pop_o}, 32'h1);
        rd(`QDP_OFS_TRANSMIT_DATA, 32'h0, "tx_read");
        rd(10'h3fc, 32'h0, "unmapped");
        // Reset in mid-run clears all state again
        acc(1'b0, 1'b0, 10'h000, 32'h0000_0000);
        rst_i = 1'b1;
        repeat (3) @(negedge mclk_i);
        rst_i = 1'b0;
        rd(`QDP_OFS_CHAIN_POINTERS, 32'h0, "ptr_rst2");
        rd(`QDP_OFS_TRANSMIT_SETUP, 32'h0, "setup_rst2");
        chk("word_rst2", tx_word_o, 32'h0);
        acc(1'b0, 1'b0, 10'h000, 32'h0000_0000);
        print_verdict();
    end
endmodule : qdp_top_tb

`default_nettype wire
